// ---- logic/bbat_mode_regs.sv ----
// Protected processor mode registers with the sticky locked bit
`timescale 1ns/1ps
module bbat_mode_regs (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] mode_b,
   output logic [7:0] prot,
   output logic [7:0] csp
);
   logic [7:0] mode_b_r, mode_b_nxt;
   logic [7:0] prot_r, prot_nxt;
   logic [7:0] csp_r, csp_nxt;

   // ***************************************************************
   // Next values
   // ***************************************************************
   always_comb begin
      prot_nxt = prot_r;
      csp_nxt = csp_r;
      mode_b_nxt = mode_b_r;
      if (wr && addr == bbat_pkg::PROT_ADDR) begin
         prot_nxt = wdata;
      end
      if (wr && addr == bbat_pkg::CSP_ADDR) begin
         csp_nxt = wdata;
      end
      if (wr && addr == bbat_pkg::MODE_B_ADDR && prot_r[bbat_pkg::MODE_WE_BIT]) begin
         mode_b_nxt = wdata;
         mode_b_nxt[bbat_pkg::LOCK_BIT] = wdata[bbat_pkg::LOCK_BIT]
            | mode_b_r[bbat_pkg::LOCK_BIT];
      end
      if (csp_nxt[bbat_pkg::CSP_SEL_BIT]) begin
         mode_b_nxt[bbat_pkg::LOCK_BIT] = 1'b1;
      end
   end

   // Register stage; reset restores defaults
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_b_r <= bbat_pkg::MODE_B_RST;
         prot_r <= bbat_pkg::PROT_RST;
         csp_r <= bbat_pkg::CSP_RST;
      end else begin
         mode_b_r <= mode_b_nxt;
         prot_r <= prot_nxt;
         csp_r <= csp_nxt;
      end
   end

   assign mode_b = mode_b_r;
   assign prot = prot_r;
   assign csp = csp_r;
endmodule

// ---- logic/bbat_pkg.sv ----
// Package of constants for the byte bus access timing block
// What this block does
// - Only single-chip mode; SFR, RAM, ROM reachable
// - All pins are ports or peripheral pins
// - Locked mode bit sticks at one
// - Count source protect forces locked bit
// - Memories reached over one-byte bus
// - Word access becomes two byte transfers
// - SFR and data flash take two cycles
// - ROM and RAM take one cycle
// - Second byte uses address plus one
package bbat_pkg;
   // ***************************************************************
   // Address map and timing
   // ***************************************************************
   localparam int ADDR_W = 16;
   localparam logic [15:0] SFR_BASE = 16'h0000;
   localparam logic [15:0] SFR_LAST = 16'h02ff;
   localparam logic [15:0] DFL_BASE = 16'h2400;
   localparam logic [15:0] DFL_LAST = 16'h2bff;
   localparam logic [15:0] RAM_BASE = 16'h0400;
   localparam logic [15:0] RAM_LAST = 16'h07ff;
   localparam logic [15:0] ROM_BASE = 16'hc000;
   localparam logic [15:0] ROM_LAST = 16'hffff;
   localparam logic [1:0] SLOW_CYCLES = 2'h2;
   localparam logic [1:0] FAST_CYCLES = 2'h1;
   // Mode register locations on the byte bus
   localparam logic [15:0] MODE_B_ADDR = 16'h0005;
   localparam logic [15:0] PROT_ADDR = 16'h000a;
   localparam logic [15:0] CSP_ADDR = 16'h001c;
   localparam int LOCK_BIT = 2;
   localparam int MODE_WE_BIT = 1;
   localparam int CSP_SEL_BIT = 7;
   localparam logic [7:0] MODE_B_RST = 8'h00;
   localparam logic [7:0] PROT_RST = 8'h00;
   localparam logic [7:0] CSP_RST = 8'h00;
   // Engine states
   typedef enum logic [1:0] {
      BBAT_IDLE = 2'b00,
      BBAT_LO = 2'b01,
      BBAT_HI = 2'b10
   } bbat_state_t;
endpackage

// ---- logic/bbat_top.sv ----
// Byte bus bridge between CPU core and on-chip memory areas
`timescale 1ns/1ps
module bbat_top (
   input wire logic CLK,
   input wire logic RST,
   input wire logic REQ,
   input wire logic REQ_WORD,
   input wire logic REQ_WR,
   input wire logic [15:0] REQ_ADDR,
   input wire logic [15:0] REQ_WDATA,
   input wire logic [7:0] BUS_RDATA,
   output logic REQ_READY,
   output logic DONE,
   output logic [15:0] RDATA,
   output logic BUS_EN,
   output logic BUS_WR,
   output logic [15:0] BUS_ADDR,
   output logic [7:0] BUS_WDATA,
   output logic BUS_ERR,
   output logic LOCKED_MODE
);
   // ***************************************************************
   // Overview
   // ***************************************************************
   // The CPU side sees one request at a time: REQ is taken on an edge
   // where REQ_READY is high, and DONE pulses once the last byte is back.
   // Behind the engine every area hangs off a single byte-wide bus, so a
   // word is always two byte transfers, low address first.
   // Slow areas (special registers, data flash) hold each byte for two
   // cycles; program memory and RAM finish a byte every cycle.
   // Unmapped start addresses never reach the bus; they answer at once with
   // BUS_ERR beside DONE so the CPU side cannot stall on a hole.
   // Limitation: the second byte of a word that runs off the end of an
   // area is not checked again; it takes the timing of where it lands.
   // ***************************************************************
   // Area decode
   // ***************************************************************
   // Holes between the areas are left unmapped on purpose: with only
   // single-chip mode there is no external bus to send them to
   // only internal areas
   function automatic logic in_map(input logic [15:0] a);
      in_map = (a <= bbat_pkg::SFR_LAST)
         || (a >= bbat_pkg::RAM_BASE && a <= bbat_pkg::RAM_LAST)
         || (a >= bbat_pkg::DFL_BASE && a <= bbat_pkg::DFL_LAST)
         || (a >= bbat_pkg::ROM_BASE);
   endfunction

   // Decoded twice, at the first byte and again at address plus one,
   // because a word may straddle two areas of different speed
   // slow areas
   function automatic logic [1:0] cyc_of(input logic [15:0] a);
      if (a <= bbat_pkg::SFR_LAST) begin
         cyc_of = bbat_pkg::SLOW_CYCLES;
      end else if (a >= bbat_pkg::DFL_BASE && a <= bbat_pkg::DFL_LAST) begin
         cyc_of = bbat_pkg::SLOW_CYCLES;
      end else begin
         cyc_of = bbat_pkg::FAST_CYCLES;
      end
   endfunction

   bbat_pkg::bbat_state_t st_r, st_nxt; // Transfer engine state
   logic [1:0] cnt_r, cnt_nxt; // Cycles left in current byte transfer
   logic word_r, word_nxt; // Word access in progress
   logic wr_r, wr_nxt; // Access is a write
   logic [15:0] addr_r, addr_nxt; // Current byte address
   logic [15:0] wd_r, wd_nxt; // Write data held
   logic [7:0] lo_r, lo_nxt; // Low byte captured
   logic [15:0] rd_r, rd_nxt; // Result to CPU
   logic done_r, done_nxt; // One-cycle completion pulse
   logic err_r, err_nxt; // Unmapped address flag, rides with done
   logic rdy_r, rdy_nxt; // Engine free to take a request
   logic bus_en_r, bus_en_nxt; // Byte transfer on the bus
   logic [7:0] bus_wd_r, bus_wd_nxt; // Byte of write data on the bus
   logic last; // Final cycle of the byte now on the bus
   logic mode_wr; // Byte write finishing on the bus this cycle
   logic [7:0] mode_b; // Second processor mode register image

   // Mode registers snoop byte writes on the internal bus
   // Only the last cycle of a byte write counts, so a slow byte that
   // stands for two cycles still updates the mode registers once
   assign mode_wr = bus_en_r && wr_r && cnt_r == 2'h1;

   bbat_mode_regs u_mode (
      .clk(CLK),
      .rst(RST),
      .wr(mode_wr),
      .addr(addr_r),
      .wdata(bus_wd_r),
      .mode_b(mode_b),
      // Protect and count source images are used only inside
      .prot(),
      .csp()
   );

   // Last cycle of the byte now on the bus
   assign last = (st_r != bbat_pkg::BBAT_IDLE) && cnt_r == 2'h1;

   // ***************************************************************
   // Engine next state
   // ***************************************************************
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      word_nxt = word_r;
      wr_nxt = wr_r;
      addr_nxt = addr_r;
      wd_nxt = wd_r;
      lo_nxt = lo_r;
      rd_nxt = rd_r;
      done_nxt = 1'b0;
      err_nxt = 1'b0;
      rdy_nxt = rdy_r;
      case (st_r)
         bbat_pkg::BBAT_IDLE: begin
            rdy_nxt = 1'b1;
            if (REQ && rdy_r) begin
               if (!in_map(REQ_ADDR)) begin
                  // Unmapped address answers at once with an error
                  done_nxt = 1'b1;
                  err_nxt = 1'b1;
               end else begin
                  st_nxt = bbat_pkg::BBAT_LO;
                  rdy_nxt = 1'b0;
                  addr_nxt = REQ_ADDR;
                  cnt_nxt = cyc_of(REQ_ADDR);
                  word_nxt = REQ_WORD;
                  wr_nxt = REQ_WR;
                  wd_nxt = REQ_WDATA;
               end
            end
         end
         bbat_pkg::BBAT_LO: begin
            if (last) begin
               lo_nxt = BUS_RDATA;
               if (word_r) begin
                  st_nxt = bbat_pkg::BBAT_HI;
                  // second byte at address plus one
                  addr_nxt = addr_r + 16'h0001;
                  cnt_nxt = cyc_of(addr_r + 16'h0001);
               end else begin
                  st_nxt = bbat_pkg::BBAT_IDLE;
                  rd_nxt = {8'h00, BUS_RDATA};
                  done_nxt = 1'b1;
                  rdy_nxt = 1'b1;
               end
            end else begin
               cnt_nxt = cnt_r - 2'h1;
            end
         end
         bbat_pkg::BBAT_HI: begin
            if (last) begin
               rd_nxt = {BUS_RDATA, lo_r};
               st_nxt = bbat_pkg::BBAT_IDLE;
               done_nxt = 1'b1;
               rdy_nxt = 1'b1;
            end else begin
               cnt_nxt = cnt_r - 2'h1;
            end
         end
         default: begin
            st_nxt = bbat_pkg::BBAT_IDLE;
         end
      endcase
      // Bus strobes are registered from the next state so that the pins
      // come straight from flops yet still line up with the address
      bus_en_nxt = (st_nxt != bbat_pkg::BBAT_IDLE);
      bus_wd_nxt = (st_nxt == bbat_pkg::BBAT_HI) ? wd_nxt[15:8] : wd_nxt[7:0];
   end

   // ***************************************************************
   // Register stage
   // ***************************************************************
   // Synchronous reset parks the engine idle with every strobe low;
   // ready rises one edge after release so no request is lost
   always_ff @(posedge CLK) begin
      if (RST) begin
         st_r <= bbat_pkg::BBAT_IDLE;
         cnt_r <= 2'h0;
         word_r <= 1'b0;
         wr_r <= 1'b0;
         addr_r <= 16'h0000;
         wd_r <= 16'h0000;
         lo_r <= 8'h00;
         rd_r <= 16'h0000;
         done_r <= 1'b0;
         err_r <= 1'b0;
         rdy_r <= 1'b0;
         bus_en_r <= 1'b0;
         bus_wd_r <= 8'h00;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         word_r <= word_nxt;
         wr_r <= wr_nxt;
         addr_r <= addr_nxt;
         wd_r <= wd_nxt;
         lo_r <= lo_nxt;
         rd_r <= rd_nxt;
         done_r <= done_nxt;
         err_r <= err_nxt;
         rdy_r <= rdy_nxt;
         bus_en_r <= bus_en_nxt;
         bus_wd_r <= bus_wd_nxt;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   // one byte transfers
   assign BUS_EN = bus_en_r;
   assign BUS_WR = wr_r;
   assign BUS_ADDR = addr_r;
   // Write byte from its own flop; no mux sits between it and the pin
   assign BUS_WDATA = bus_wd_r;
   assign REQ_READY = rdy_r;
   assign DONE = done_r;
   assign RDATA = rd_r;
   assign BUS_ERR = err_r;
   assign LOCKED_MODE = mode_b[bbat_pkg::LOCK_BIT];
endmodule

// ---- sim/bbat_checker.sv ----
// Timing checker for the byte bus bridge
`timescale 1ns/1ps
module bbat_checker (
   input wire logic CLK,
   input wire logic RST,
   input wire logic REQ,
   input wire logic REQ_WORD,
   input wire logic REQ_WR,
   input wire logic [15:0] REQ_ADDR,
   input wire logic [15:0] REQ_WDATA,
   input wire logic REQ_READY,
   input wire logic DONE,
   input wire logic BUS_EN,
   input wire logic BUS_WR,
   input wire logic [15:0] BUS_ADDR,
   input wire logic [7:0] BUS_WDATA,
   input wire logic BUS_ERR,
   input wire logic LOCKED_MODE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   err_with_done_a: assert property (BUS_ERR |-> DONE && !BUS_EN)
      else $error("error flag without done");
   word_late_a: assert property (REQ && REQ_READY && REQ_WORD |=> !DONE ##1 !DONE)
      else $error("word returned early");
   plus_one_a: assert property (BUS_EN && $past(BUS_EN) && BUS_ADDR != $past(BUS_ADDR)
      |-> BUS_ADDR == $past(BUS_ADDR) + 16'h1) else $error("second byte address wrong");
   slow_hold_a: assert property (BUS_EN && !$past(BUS_EN) && BUS_ADDR <= 16'h02ff
      |=> BUS_EN && $stable(BUS_ADDR)) else $error("slow byte too short");
   fast_once_a: assert property (BUS_EN && $past(BUS_EN) && BUS_ADDR >= 16'hc000
      |-> BUS_ADDR != $past(BUS_ADDR)) else $error("fast byte held too long");
   lock_stick_a: assert property (LOCKED_MODE |=> LOCKED_MODE)
      else $error("locked bit cleared");
   word_fast_a: assert property (REQ && REQ_READY && REQ_WORD && REQ_ADDR >= 16'hc000
      && REQ_ADDR != 16'hffff |=> BUS_EN [*2] ##1 DONE && !BUS_EN)
      else $error("fast word not two transfers");
   byte_exact_a: assert property (REQ && REQ_READY && !REQ_WORD && REQ_ADDR >= 16'hc000
      |=> BUS_EN && BUS_ADDR == $past(REQ_ADDR) ##1 DONE) else $error("byte transfer wrong");
   ready_done_a: assert property (DONE |-> REQ_READY)
      else $error("not ready at done");
   wdata_order_a: assert property (REQ && REQ_READY && REQ_WORD && REQ_WR
      && REQ_ADDR >= 16'h0400 && REQ_ADDR <= 16'h07fe
      |=> BUS_WR && BUS_WDATA == $past(REQ_WDATA[7:0])
      ##1 BUS_WR && BUS_WDATA == $past(REQ_WDATA[15:8], 2))
      else $error("word write bytes out of order");
endmodule
bind bbat_top bbat_checker bbat_checker_i (.CLK(CLK), .RST(RST), .REQ(REQ),
   .REQ_WORD(REQ_WORD), .REQ_WR(REQ_WR), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA),
   .REQ_READY(REQ_READY), .DONE(DONE), .BUS_EN(BUS_EN), .BUS_WR(BUS_WR),
   .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_ERR(BUS_ERR),
   .LOCKED_MODE(LOCKED_MODE));

// ---- sim/bbat_mem_model.sv ----
// Memory-side model answering byte transfers
`timescale 1ns/1ps
module bbat_mem_model (
   input wire logic clk,
   input wire logic en,
   input wire logic [15:0] addr,
   output logic [7:0] rdata
);
   logic [7:0] junk_r = 8'h00; // Churns so idle data never looks valid
   always @(posedge clk) begin
      junk_r <= junk_r + 8'h3b;
   end
   assign rdata = en ? (addr[7:0] ^ addr[15:8] ^ 8'h5a) : junk_r;
endmodule

// ---- sim/byte_bus_access_timing_tb.sv ----
// Self-checking bench for the byte bus bridge
`timescale 1ns/1ps
module byte_bus_access_timing_tb;
   logic CLK = 1'b0, RST = 1'b1, REQ = 1'b0, REQ_WORD = 1'b0, REQ_WR = 1'b0;
   logic [15:0] REQ_ADDR = 16'h0000, REQ_WDATA = 16'h0000, RDATA, BUS_ADDR, got, exp;
   logic [7:0] BUS_RDATA, BUS_WDATA;
   logic REQ_READY, DONE, BUS_EN, BUS_WR, BUS_ERR, LOCKED_MODE;
   int err_total = 0, total_checks = 0, cyc = 0, n;
   typedef struct {logic w; logic [15:0] a; int n; logic e;} bbat_row_t;
   // Width, address, edges from raising REQ to DONE, error flag
   bbat_row_t rows[10] = '{'{1'h0, 16'h0400, 2, 1'h0}, '{1'h0, 16'h0401, 2, 1'h0},
      '{1'h0, 16'hc003, 2, 1'h0}, '{1'h0, 16'h0011, 3, 1'h0}, '{1'h1, 16'hc010, 3, 1'h0},
      '{1'h1, 16'h0405, 3, 1'h0}, '{1'h1, 16'h0020, 5, 1'h0}, '{1'h1, 16'h2401, 5, 1'h0},
      '{1'h1, 16'hffff, 4, 1'h0}, '{1'h0, 16'h1000, 1, 1'h1}};
   bbat_top bbat_top_i (.CLK(CLK), .RST(RST), .REQ(REQ), .REQ_WORD(REQ_WORD),
      .REQ_WR(REQ_WR), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .BUS_RDATA(BUS_RDATA),
      .REQ_READY(REQ_READY), .DONE(DONE), .RDATA(RDATA), .BUS_EN(BUS_EN), .BUS_WR(BUS_WR),
      .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_ERR(BUS_ERR),
      .LOCKED_MODE(LOCKED_MODE));
   bbat_mem_model bbat_mem_model_i (.clk(CLK), .en(BUS_EN), .addr(BUS_ADDR),
      .rdata(BUS_RDATA));
   initial begin
      forever #12.5 CLK = ~CLK;
   end
   // Expected memory byte, kept apart from the model on purpose
   function automatic logic [7:0] md(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5a;
   endfunction
   task chk(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task rst16;
      @(posedge CLK);
      RST <= 1'b1;
      repeat (16) @(posedge CLK);
      RST <= 1'b0;
      repeat (2) @(posedge CLK);
   endtask
   // One access; request held only up to the taking edge
   task acc(input logic w, input logic wr, input logic [15:0] a, input logic [15:0] d);
      @(posedge CLK);
      REQ <= 1'b1;
      REQ_WORD <= w;
      REQ_WR <= wr;
      REQ_ADDR <= a;
      REQ_WDATA <= d;
      n = 0;
      // n counts edges from raising REQ; REQ drops at the taking edge
      do begin
         @(posedge CLK);
         REQ <= 1'b0;
         #1;
         n++;
      end while (DONE !== 1'b1 && n < 20);
      got = RDATA;
   endtask
   task lk(input logic e);
      @(posedge CLK);
      #1;
      chk({15'h0, LOCKED_MODE}, {15'h0, e});
   endtask
   // Hang guard, well above the expected hundred or so cycles
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         close_out;
      end
   end
   initial begin
      rst16;
      foreach (rows[i]) begin
         acc(rows[i].w, 1'h0, rows[i].a, 16'h0000);
         chk(16'(n), 16'(rows[i].n));
         chk({15'h0, BUS_ERR}, {15'h0, rows[i].e});
         exp = rows[i].w ? {md(rows[i].a + 16'h1), md(rows[i].a)} : {8'h00, md(rows[i].a)};
         if (!rows[i].e) chk(got, exp);
         $display("row %0d ends", i);
      end
      acc(1'h1, 1'h1, 16'h0406, 16'hbeef);
      chk(16'(n), 16'h0003);
      $display("word write test ends");
      acc(1'h0, 1'h1, bbat_pkg::MODE_B_ADDR, 16'h0004);
      lk(1'h0);
      acc(1'h0, 1'h1, bbat_pkg::PROT_ADDR, 16'h0002);
      acc(1'h0, 1'h1, bbat_pkg::MODE_B_ADDR, 16'h0004);
      lk(1'h1);
      acc(1'h0, 1'h1, bbat_pkg::MODE_B_ADDR, 16'h0000);
      lk(1'h1);
      $display("lock test ends");
      rst16;
      lk(1'h0);
      acc(1'h0, 1'h1, bbat_pkg::CSP_ADDR, 16'h0080);
      lk(1'h1);
      $display("count source test ends");
      close_out;
   end
endmodule
